// [verilog/serial_access_regs.svh]
`ifndef SERIAL_ACCESS_REGS_SVH
`define SERIAL_ACCESS_REGS_SVH

// register map
`define RES_FIRST_ADDR      16'he50c
`define RES_LAST_ADDR       16'he526
`define EVENT_FLAGS_0_ADDR  16'he502
`define DEV_CONFIG_ADDR     16'he618

// fields and reset values
`define SAMPLE_READY_BIT    17
`define FUNC_SEL_MSB        1
`define FUNC_SEL_LSB        0
`define FUNC_SEL_DATA_READY 2'h0
`define DEV_CONFIG_RESET    16'h0000
`define IIC_SLAVE_ADDR      7'h38

// register widths in bits
`define REG_W8              6'h08
`define REG_W16             6'h10
`define REG_W32             6'h20

// frame lengths
`define SPI_HDR_BITS        6'h18
`define IIC_BYTE_BITS       4'h8

// timing
`define CLK_PERIOD_NS       50
`define SCLK_MAX_HZ         2500000
`define READY_DELAY_NS      70
`define READY_LOW_NS        10000
`define READY_DELAY_CYC     ((`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_LOW_CYC       (`READY_LOW_NS / `CLK_PERIOD_NS)

`endif

// [verilog/serial_access_pkg.sv]
package serial_access_pkg;
	typedef enum logic [1:0] {SPI_HDR, SPI_WR, SPI_RD, SPI_END} spi_state_e;
	typedef enum logic [2:0] {IIC_IDLE, IIC_RX, IIC_ACK, IIC_TX, IIC_MACK} iic_state_e;
endpackage : serial_access_pkg

// [verilog/stream_fifo.sv]
module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  logic             i_clk,
	input  logic             i_rst_b,
	// filling side
	input  logic             i_in_valid,
	output logic             o_in_ready,
	input  logic [WIDTH-1:0] i_in_data,
	// draining side
	output logic             o_out_valid,
	input  logic             i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready  = count != (AW+1)'(DEPTH);
	assign o_out_valid = count != '0;
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
			if (push && !pop) begin
				count <= count + (AW+1)'(1);
			end else if (pop && !push) begin
				count <= count - (AW+1)'(1);
			end
		end
	end
endmodule : stream_fifo

// [verilog/serial_register_access_port.sv]
// Functional notes
// - 27 result registers refreshed per sample set, read singly or in bursts
// - i2c write phase loads the register pointer, kept for the read phase
// - i2c read address acked, then register sent msbyte and msbit first
// - host ack on a register's last byte advances pointer, next register follows
// - ready pin acts as data ready only when function select is 00
// - ready pin falls about 70 ns after the sample ready flag sets
// - ready pin stays low 10 us then returns high
// - spi is slave only, sclk at most 2.5 MHz
// - spi data changes on falling sclk, sampled on rising, msb first
// - miso released whenever the device is not transmitting
// - ss high aborts the transfer and releases the bus
// - after the last bit host raises ss and sclk, lines go idle
// - spi read: bit0 set, address, data from the next falling edge
// - spi burst continues with the next result register until ss rises or the last result register has been sent
`include "serial_access_regs.svh"

module serial_register_access_port #(
	parameter int DATA_W     = 32,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input  logic              i_clk,
	input  logic              i_rst_b,
	// sample stream from the measurement path
	input  logic              i_sample_valid,
	output logic              o_sample_ready,
	input  logic [DATA_W-1:0] i_sample_data,
	// spi pins
	input  logic              i_sclk,
	input  logic              i_mosi,
	input  logic              i_ss_b,
	output logic              o_miso,
	output logic              o_miso_en_b,
	// i2c pins
	input  logic              i_scl,
	input  logic              i_sda,
	output logic              o_sda,
	output logic              o_sda_en_b,
	// ready pin
	output logic              o_zero_cross_or_data_ready_pin
);
	import serial_access_pkg::*;

	localparam logic [4:0] LAST_IDX  = 5'(`RES_LAST_ADDR - `RES_FIRST_ADDR);
	localparam logic [7:0] RDY_TOTAL = 8'(`READY_DELAY_CYC + `READY_LOW_CYC);
	localparam logic [7:0] RDY_LOW   = 8'(`READY_LOW_CYC);

	logic [4:0]        pin_meta;
	logic [4:0]        pin_sync;
	logic [4:0]        pin_prev;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              ss_high;
	logic              mosi;
	logic              scl_rise;
	logic              scl_fall;
	logic              sda;
	logic              iic_start;
	logic              iic_stop;
	spi_state_e        spi_state;
	logic [5:0]        spi_cnt;
	logic [31:0]       spi_sh;
	logic [15:0]       spi_ptr;
	logic [15:0]       spi_next;
	logic [31:0]       spi_next_word;
	logic [31:0]       spi_tx;
	logic              spi_tx_msb;
	logic [5:0]        spi_rem;
	logic              spi_wr;
	logic [15:0]       spi_wr_addr;
	logic [31:0]       spi_wr_data;
	logic [15:0]       spi_wr_low;
	iic_state_e        iic_state;
	logic [3:0]        iic_bit;
	logic [7:0]        iic_sh;
	logic              iic_first;
	logic              iic_rw;
	logic [1:0]        iic_nbyte;
	logic [15:0]       iic_ptr;
	logic [15:0]       iic_next;
	logic [31:0]       iic_ptr_word;
	logic [31:0]       iic_tx;
	logic [5:0]        iic_rem;
	logic              iic_sda_low;
	logic [DATA_W-1:0] results [LAST_IDX + 5'h01];
	logic [4:0]        load_idx;
	logic              f_valid;
	logic              f_take;
	logic [DATA_W-1:0] f_data;
	logic              sample_set;
	logic              sample_ready_flag;
	logic [15:0]       dev_cfg;
	logic              sel_drdy;
	logic [7:0]        rdy_cnt;
	logic [7:0]        next_rdy_cnt;
	logic [7:0]        pin_low_len;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic in_burst(input logic [15:0] a);
		return a >= `RES_FIRST_ADDR && a <= `RES_LAST_ADDR;
	endfunction : in_burst

	function automatic logic [5:0] reg_width(input logic [15:0] a);
		if (in_burst(a) || a == `EVENT_FLAGS_0_ADDR) begin
			return `REG_W32;
		end else if (a == `DEV_CONFIG_ADDR) begin
			return `REG_W16;
		end
		return `REG_W8;
	endfunction : reg_width

	// value left aligned so the msb always leaves first
	function automatic logic [31:0] reg_read(input logic [15:0] a);
		logic [31:0] v;
		v = '0;
		if (in_burst(a)) begin
			v = results[5'(a - `RES_FIRST_ADDR)];
		end else if (a == `EVENT_FLAGS_0_ADDR) begin
			v = 32'(sample_ready_flag) << `SAMPLE_READY_BIT;
		end else if (a == `DEV_CONFIG_ADDR) begin
			v = {16'h0000, dev_cfg};
		end
		return v << (`REG_W32 - reg_width(a));
	endfunction : reg_read

	////////////////////////////////////////////////////////////////////////////
	// pins come from the host's clocks: two flops before any use
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pin_meta <= '1;
			pin_sync <= '1;
			pin_prev <= '1;
		end else begin
			pin_meta <= {i_sclk, i_mosi, i_ss_b, i_scl, i_sda};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// sclk is only ever sampled, never made here
	assign ss_high   = pin_sync[2];
	assign mosi      = pin_sync[3];
	assign sclk_rise = pin_sync[4] && !pin_prev[4] && !ss_high;
	assign sclk_fall = !pin_sync[4] && pin_prev[4] && !ss_high;
	assign sda       = pin_sync[0];
	assign scl_rise  = pin_sync[1] && !pin_prev[1];
	assign scl_fall  = !pin_sync[1] && pin_prev[1];
	assign iic_start = pin_sync[1] && pin_prev[1] && pin_prev[0] && !sda;
	assign iic_stop  = pin_sync[1] && pin_prev[1] && !pin_prev[0] && sda;

	////////////////////////////////////////////////////////////////////////////
	assign spi_next   = spi_ptr + 16'h0001;
	assign spi_tx_msb = spi_tx[31];
	assign spi_wr_low = spi_wr_data[15:0];

	// a process, not an assign, so it follows the registers the function reads
	always_comb begin
		spi_next_word = reg_read(spi_next);
		iic_ptr_word  = reg_read(iic_ptr);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || ss_high) begin
			spi_state   <= SPI_HDR;
			spi_cnt     <= '0;
			spi_sh      <= '0;
			spi_ptr     <= '0;
			spi_tx      <= '0;
			spi_rem     <= '0;
			spi_wr      <= 1'b0;
			spi_wr_addr <= '0;
			spi_wr_data <= '0;
			o_miso      <= 1'b0;
			o_miso_en_b <= 1'b1;
		end else begin
			spi_wr <= 1'b0;
			unique case (spi_state)
				SPI_HDR: if (sclk_rise) begin
					spi_sh  <= {spi_sh[30:0], mosi};
					spi_cnt <= spi_cnt + 6'h01;
					if (spi_cnt == `SPI_HDR_BITS - 6'h01) begin
						spi_ptr <= {spi_sh[14:0], mosi};
						spi_cnt <= '0;
						if (spi_sh[15]) begin
							spi_state <= SPI_RD;
							spi_tx    <= reg_read({spi_sh[14:0], mosi});
							spi_rem   <= reg_width({spi_sh[14:0], mosi});
						end else begin
							spi_state <= SPI_WR;
						end
					end
				end
				SPI_WR: if (sclk_rise) begin
					spi_sh  <= {spi_sh[30:0], mosi};
					spi_cnt <= spi_cnt + 6'h01;
					if (spi_cnt + 6'h01 == reg_width(spi_ptr)) begin
						spi_wr      <= 1'b1;
						spi_wr_addr <= spi_ptr;
						spi_wr_data <= {spi_sh[30:0], mosi};
						spi_state   <= SPI_END;
					end
				end
				SPI_RD: if (sclk_fall) begin
					o_miso_en_b <= 1'b0;
					if (spi_rem != '0) begin
						o_miso  <= spi_tx[31];
						spi_tx  <= spi_tx << 1;
						spi_rem <= spi_rem - 6'h01;
					end else if (in_burst(spi_ptr) && spi_ptr != `RES_LAST_ADDR) begin
						spi_ptr <= spi_next;
						o_miso  <= spi_next_word[31];
						spi_tx  <= spi_next_word << 1;
						spi_rem <= reg_width(spi_next) - 6'h01;
					end else begin
						o_miso_en_b <= 1'b1;
						spi_state   <= SPI_END;
					end
				end
				SPI_END: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// open drain: the pin only ever pulls low
	assign o_sda      = 1'b0;
	assign o_sda_en_b = !iic_sda_low;
	assign iic_next   = iic_ptr + 16'h0001;

	always_ff @(posedge i_clk) begin
		if (!i_rst_b || iic_stop) begin
			iic_state   <= IIC_IDLE;
			iic_bit     <= '0;
			iic_sh      <= '0;
			iic_first   <= 1'b0;
			iic_rw      <= 1'b0;
			iic_nbyte   <= '0;
			iic_tx      <= '0;
			iic_rem     <= '0;
			iic_sda_low <= 1'b0;
			if (!i_rst_b) begin
				iic_ptr <= '0;
			end
		end else if (iic_start) begin
			iic_state   <= IIC_RX;
			iic_bit     <= '0;
			iic_first   <= 1'b1;
			iic_nbyte   <= '0;
			iic_sda_low <= 1'b0;
		end else begin
			unique case (iic_state)
				IIC_IDLE: ;
				IIC_RX: begin
					if (scl_rise && iic_bit != `IIC_BYTE_BITS) begin
						iic_sh  <= {iic_sh[6:0], sda};
						iic_bit <= iic_bit + 4'h1;
					end
					if (scl_fall && iic_bit == `IIC_BYTE_BITS) begin
						iic_bit   <= '0;
						iic_first <= 1'b0;
						if (!iic_first) begin
							iic_sda_low <= 1'b1;
							iic_state   <= IIC_ACK;
							if (iic_nbyte == 2'h0) begin
								iic_ptr[15:8] <= iic_sh;
							end else if (iic_nbyte == 2'h1) begin
								iic_ptr[7:0] <= iic_sh;
							end
							if (iic_nbyte != 2'h2) begin
								iic_nbyte <= iic_nbyte + 2'h1;
							end
						end else if (iic_sh[7:1] == `IIC_SLAVE_ADDR) begin
							iic_sda_low <= 1'b1;
							iic_rw      <= iic_sh[0];
							iic_state   <= IIC_ACK;
						end else begin
							iic_state <= IIC_IDLE;
						end
					end
				end
				IIC_ACK: if (scl_fall) begin
					if (iic_rw) begin
						iic_sda_low <= !iic_ptr_word[31];
						iic_tx      <= iic_ptr_word << 1;
						iic_rem     <= reg_width(iic_ptr) - 6'h01;
						iic_bit     <= 4'h1;
						iic_state   <= IIC_TX;
					end else begin
						iic_sda_low <= 1'b0;
						iic_state   <= IIC_RX;
					end
				end
				IIC_TX: if (scl_fall) begin
					if (iic_bit == `IIC_BYTE_BITS) begin
						iic_sda_low <= 1'b0;
						iic_bit     <= '0;
						iic_state   <= IIC_MACK;
					end else begin
						iic_sda_low <= !iic_tx[31];
						iic_tx      <= iic_tx << 1;
						iic_rem     <= iic_rem - 6'h01;
						iic_bit     <= iic_bit + 4'h1;
					end
				end
				IIC_MACK: if (scl_rise) begin
					if (sda) begin
						iic_state <= IIC_IDLE;
					end else begin
						iic_state <= IIC_TX;
						if (iic_rem == '0) begin
							iic_ptr <= iic_next;
							iic_tx  <= reg_read(iic_next);
							iic_rem <= reg_width(iic_next);
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// loading stalls during a read so a burst sees one coherent sample set
	assign f_take = !(spi_state == SPI_RD || iic_state == IIC_TX || iic_state == IIC_MACK
		|| (iic_state == IIC_ACK && iic_rw));
	assign sample_set = f_valid && f_take && load_idx == LAST_IDX;

	stream_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_sample_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (i_sample_valid),
		.o_in_ready  (o_sample_ready),
		.i_in_data   (i_sample_data),
		.o_out_valid (f_valid),
		.i_out_ready (f_take),
		.o_out_data  (f_data)
	);

	always_ff @(posedge i_clk) begin
		if (f_valid && f_take) begin
			results[load_idx] <= f_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			load_idx <= '0;
		end else if (f_valid && f_take) begin
			load_idx <= (load_idx == LAST_IDX) ? '0 : load_idx + 5'h01;
		end
	end

	// a new sample set wins over a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sample_ready_flag <= 1'b0;
		end else if (sample_set) begin
			sample_ready_flag <= 1'b1;
		end else if (spi_wr && spi_wr_addr == `EVENT_FLAGS_0_ADDR
			&& spi_wr_data[`SAMPLE_READY_BIT]) begin
			sample_ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			dev_cfg <= `DEV_CONFIG_RESET;
		end else if (spi_wr && spi_wr_addr == `DEV_CONFIG_ADDR) begin
			dev_cfg <= spi_wr_low;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// zero crossing is not produced here: other selections hold the pin high
	assign sel_drdy     = dev_cfg[`FUNC_SEL_MSB:`FUNC_SEL_LSB] == `FUNC_SEL_DATA_READY;
	assign next_rdy_cnt = sample_set ? RDY_TOTAL : (rdy_cnt != '0 ? rdy_cnt - 8'h01 : '0);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			rdy_cnt                        <= '0;
			o_zero_cross_or_data_ready_pin <= 1'b1;
		end else begin
			rdy_cnt                        <= next_rdy_cnt;
			o_zero_cross_or_data_ready_pin <= !(sel_drdy && next_rdy_cnt != '0
				&& next_rdy_cnt <= RDY_LOW);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	always_ff @(posedge i_clk) begin
		pin_low_len <= o_zero_cross_or_data_ready_pin ? '0 : pin_low_len + 8'h01;
	end

	sequence pin_wait_then_fall;
		o_zero_cross_or_data_ready_pin [*2] ##1 !o_zero_cross_or_data_ready_pin;
	endsequence

	sequence first_bit_out;
		!o_miso_en_b && o_miso == $past(spi_tx_msb);
	endsequence

	a_pin_fall_delay: assert property (sample_set && sel_drdy |=> pin_wait_then_fall)
		else $error("ready pin did not fall two cycles after the flag");
	a_pin_low_width: assert property ($rose(o_zero_cross_or_data_ready_pin) && sel_drdy
		|-> pin_low_len == RDY_LOW)
		else $error("ready pin low time wrong");
	a_pin_func_sel: assert property (!sel_drdy |=> o_zero_cross_or_data_ready_pin)
		else $error("ready pin pulsed while not selected");
	a_flag_set_wins: assert property (sample_set |=> sample_ready_flag)
		else $error("sample ready flag not set");
	a_miso_abort: assert property (ss_high |=> o_miso_en_b && spi_state == SPI_HDR)
		else $error("miso still driven after ss rose");
	a_miso_idle_hiz: assert property (spi_state != SPI_RD |-> o_miso_en_b)
		else $error("miso driven outside a read");
	a_miso_falling_only: assert property (!sclk_fall && !ss_high |=> $stable(o_miso))
		else $error("miso changed off a falling edge");
	a_spi_first_bit: assert property (sclk_fall && spi_state == SPI_RD && o_miso_en_b
		&& spi_rem != '0 |=> first_bit_out)
		else $error("read data not driven on first falling edge");
	a_burst_next_reg: assert property (sclk_fall && spi_state == SPI_RD && spi_rem == '0
		&& in_burst(spi_ptr) && spi_ptr != `RES_LAST_ADDR
		|=> spi_ptr == $past(spi_ptr) + 16'h0001 && spi_rem == `REG_W32 - 6'h01)
		else $error("burst did not advance to the next register");
	a_spi_write_cfg: assert property (spi_wr && spi_wr_addr == `DEV_CONFIG_ADDR
		|=> dev_cfg == $past(spi_wr_low))
		else $error("configuration write lost");
	a_iic_addr_ack: assert property (scl_fall && iic_state == IIC_RX && iic_first
		&& iic_bit == `IIC_BYTE_BITS && iic_sh[7:1] == `IIC_SLAVE_ADDR
		|=> iic_sda_low && iic_state == IIC_ACK)
		else $error("own address not acknowledged");
	a_iic_ptr_next: assert property (scl_rise && iic_state == IIC_MACK && !sda
		&& iic_rem == '0 |=> iic_ptr == $past(iic_ptr) + 16'h0001 && iic_rem == `REG_W32)
		else $error("i2c burst pointer did not advance");
endmodule : serial_register_access_port

// [verif/host_master_model.sv]
`include "serial_access_regs.svh"

module host_master_model (
	// clock
	input  logic        i_clk,
	// spi pins
	output logic        o_sclk,
	output logic        o_mosi,
	output logic        o_ss_b,
	input  logic        i_miso,
	input  logic        i_miso_en_b,
	// i2c pins
	output logic        o_scl,
	output logic        o_sda,
	input  logic        i_sda,
	// received registers
	output logic [31:0] o_word,
	output logic        o_word_valid,
	output int          o_ack_errs
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{o_sclk, o_mosi, o_ss_b, o_scl, o_sda} = 5'h1f;
		o_word = 32'h0;
		o_word_valid = 1'b0;
		o_ack_errs = 0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	// extra idle edge keeps the strobe from being set twice in one step
	task automatic publish(input logic [31:0] v);
		o_word       <= v;
		o_word_valid <= 1'b1;
		tick(1);
		o_word_valid <= 1'b0;
		tick(1);
	endtask : publish

	////////////////////////////////////////////////////////////////////////////////
	// spi master: 400 ns clock, data taken late in the high phase since the
	// device only sees the clock edges a few cycles after they happen
	task automatic spi_xfer(input logic [23:0] hdr, input logic [63:0] wd,
			input int nbits, input bit pub);
		logic [63:0] rx;
		rx = 64'h0;
		tick(1);
		o_ss_b <= 1'b0;
		tick(4);
		for (int i = 0; i < 24 + nbits; i++) begin
			o_sclk <= 1'b0;
			o_mosi <= (i < 24) ? hdr[23 - i] : wd[87 - i];
			tick(4);
			o_sclk <= 1'b1;
			tick(4);
			if (i >= 24)
				rx = {rx[62:0], i_miso_en_b ? ~rx[0] : i_miso};
		end
		o_ss_b <= 1'b1;
		o_mosi <= ~o_mosi;
		tick(4);
		if (pub && nbits == 64)
			publish(rx[63:32]);
		if (pub)
			publish(rx[31:0]);
	endtask : spi_xfer

	////////////////////////////////////////////////////////////////////////////////
	// i2c master
	task automatic iic_bit(input logic b, output logic r);
		o_scl <= 1'b0;
		tick(1);
		o_sda <= b;
		tick(3);
		o_scl <= 1'b1;
		tick(4);
		r = i_sda;
	endtask : iic_bit

	// start, repeated start or stop, depending on the sda move during scl high
	task automatic iic_cond(input logic from, input logic to);
		o_scl <= 1'b0;
		tick(1);
		o_sda <= from;
		tick(3);
		o_scl <= 1'b1;
		tick(4);
		o_sda <= to;
		tick(4);
	endtask : iic_cond

	task automatic iic_tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			iic_bit(d[i], r);
		iic_bit(1'b1, r);
		if (r !== 1'b0)
			o_ack_errs <= o_ack_errs + 1;
	endtask : iic_tx

	task automatic iic_burst(input logic [15:0] addr, input int nregs);
		logic [31:0] w;
		logic        r;
		w = 32'h0;
		tick(1);
		iic_cond(1'b1, 1'b0);
		iic_tx({`IIC_SLAVE_ADDR, 1'b0});
		iic_tx(addr[15:8]);
		iic_tx(addr[7:0]);
		iic_cond(1'b1, 1'b0);
		iic_tx({`IIC_SLAVE_ADDR, 1'b1});
		// caller keeps the burst inside the result range
		for (int k = 0; k < 4 * nregs; k++) begin
			for (int i = 0; i < 8; i++) begin
				iic_bit(1'b1, r);
				w = {w[30:0], r};
			end
			iic_bit(k == 4 * nregs - 1, r);
			if (k % 4 == 3)
				publish(w);
		end
		iic_cond(1'b0, 1'b1);
	endtask : iic_burst
endmodule : host_master_model

// [verif/tb.sv]
`include "serial_access_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        rst_b;
	logic        s_valid;
	logic        s_ready;
	logic [31:0] s_data;
	logic        sclk;
	logic        mosi;
	logic        ss_b;
	logic        miso;
	logic        miso_en_b;
	logic        scl;
	logic        sda_h;
	logic        sda_o;
	logic        sda_en_b;
	logic        ready_pin;
	logic [31:0] word;
	logic        word_valid;
	int          ack_errs;
	int          miscompares;
	int          comparisons;
	logic [31:0] words [0:80];
	logic [31:0] expq [$];
	wire         sda_w = sda_h & (sda_en_b | sda_o);

	serial_register_access_port #(.DATA_W(32), .FIFO_DEPTH(8)) u_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_sample_valid(s_valid), .o_sample_ready(s_ready),
		.i_sample_data(s_data), .i_sclk(sclk), .i_mosi(mosi), .i_ss_b(ss_b), .o_miso(miso),
		.o_miso_en_b(miso_en_b), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o),
		.o_sda_en_b(sda_en_b), .o_zero_cross_or_data_ready_pin(ready_pin)
	);

	host_master_model u_host (
		.i_clk(clk), .o_sclk(sclk), .o_mosi(mosi), .o_ss_b(ss_b), .i_miso(miso),
		.i_miso_en_b(miso_en_b), .o_scl(scl), .o_sda(sda_h), .i_sda(sda_w),
		.o_word(word), .o_word_valid(word_valid), .o_ack_errs(ack_errs)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic note(input logic [31:0] v);
		expq.push_back(v);
	endtask : note

	// valid stays up across words so it is never set twice in one step
	task automatic push(input int first, input int n);
		logic r;
		@(posedge clk);
		for (int k = 0; k < n; k++) begin
			s_data  <= words[first + k];
			s_valid <= 1'b1;
			do begin
				@(negedge clk);
				r = s_ready;
				@(posedge clk);
			end while (r !== 1'b1);
		end
		s_valid <= 1'b0;
	endtask : push

	task automatic pulse_check();
		int n;
		n = 0;
		for (int i = 0; i < 60 && ready_pin !== 1'b0; i++)
			@(negedge clk);
		while (ready_pin === 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check(n, `READY_LOW_CYC);
	endtask : pulse_check

	// oldest note is matched against every register the host publishes
	always @(posedge clk) begin
		if (word_valid === 1'b1)
			check(word, expq.pop_front());
	end

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		rst_b = 1'b0;
		s_valid = 1'b0;
		s_data = 32'h0;
		void'($urandom(16));
		foreach (words[i])
			words[i] = $urandom();
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		check(ready_pin, 1'b1);
		check(miso_en_b, 1'b1);
		check(sda_en_b, 1'b1);
		check(s_ready, 1'b1);
		push(0, 27);
		pulse_check();
		note(32'h1 << `SAMPLE_READY_BIT);
		u_host.spi_xfer({8'h01, `EVENT_FLAGS_0_ADDR}, 64'h0, 32, 1'b1);
		u_host.spi_xfer({8'h00, `EVENT_FLAGS_0_ADDR}, {32'h1 << `SAMPLE_READY_BIT, 32'h0}, 32,
			1'b0);
		note(32'h0);
		u_host.spi_xfer({8'h01, `EVENT_FLAGS_0_ADDR}, 64'h0, 32, 1'b1);
		note(32'h0);
		u_host.spi_xfer({8'h01, 16'hebff}, 64'h0, 8, 1'b1);
		note(words[24]);
		note(words[25]);
		fork
			u_host.spi_xfer({8'h01, `RES_FIRST_ADDR + 16'd24}, 64'h0, 64, 1'b1);
			begin
				wait (miso_en_b === 1'b0);
				push(27, 8);
				@(negedge clk);
				check(s_ready, 1'b0);
			end
		join
		repeat (2) @(negedge clk);
		check(miso_en_b, 1'b1);
		u_host.spi_xfer({8'h01, `RES_FIRST_ADDR}, 64'h0, 8, 1'b0);
		repeat (2) @(negedge clk);
		check(miso_en_b, 1'b1);
		push(35, 19);
		pulse_check();
		for (int k = 24; k < 27; k++)
			note(words[27 + k]);
		u_host.iic_burst(`RES_FIRST_ADDR + 16'd24, 3);
		check(ack_errs, 32'h0);
		u_host.spi_xfer({8'h00, `DEV_CONFIG_ADDR}, {16'h0001, 48'h0}, 16, 1'b0);
		note(32'h0000_0001);
		u_host.spi_xfer({8'h01, `DEV_CONFIG_ADDR}, 64'h0, 16, 1'b1);
		push(54, 27);
		n = 0;
		repeat (300) begin
			@(negedge clk);
			if (ready_pin !== 1'b1)
				n++;
		end
		check(n, 32'h0);
		// a note never answered would otherwise go unnoticed
		check(expq.size(), 32'h0);
		final_report();
	end
endmodule : tb
